// ===== core/sfp_defs.vh
`ifndef SFP_DEFS_VH
`define SFP_DEFS_VH

// Serial frame positions (bit counter values)
`define SFP_CMD_LAST     4'h5
`define SFP_DATA_FIRST   4'h1
`define SFP_DATA_LAST    4'hE
`define SFP_FRAME_LAST   4'hF
`define SFP_CNT_ZERO     4'h0
`define SFP_CNT_ONE      4'h1

// Command codes, low four bits; bit 4 picks timing or row erase
`define SFP_CMD_SEL_BIT  4
`define SFP_CMD_LD_CFG   4'h0
`define SFP_CMD_ROW_ERA  4'h1
`define SFP_CMD_LD_PROG  4'h2
`define SFP_CMD_LD_DATA  4'h3
`define SFP_CMD_RD_PROG  4'h4
`define SFP_CMD_RD_DATA  4'h5
`define SFP_CMD_INC      4'h6
`define SFP_CMD_BEGIN    4'h8
`define SFP_CMD_BULK_PRG 4'h9
`define SFP_CMD_END      4'hA
`define SFP_CMD_BULK_DAT 4'hB

// Address map
`define SFP_CFG_BIT      13
`define SFP_CFG_BASE     14'h2000
`define SFP_ADDR_ZERO    14'h0000
`define SFP_ADDR_STEP    13'h0001
`define SFP_DEVID_OFS    13'h0006
`define SFP_CAL1_OFS     13'h0008
`define SFP_CAL2_OFS     13'h0009
`define SFP_ROW_ZERO     4'h0
`define SFP_WORD_ONES    14'h3fff
`define SFP_WORD_ZERO    14'h0000
`define SFP_BYTE_PAD     6'h00

// Operation codes on the memory stream
`define SFP_OP_PROG_INT  4'h0
`define SFP_OP_PROG_EXT  4'h1
`define SFP_OP_DATA_INT  4'h2
`define SFP_OP_DATA_EXT  4'h3
`define SFP_OP_END       4'h4
`define SFP_OP_BULK_PRG  4'h5
`define SFP_OP_BULK_DAT  4'h6
`define SFP_OP_ROW_ERA   4'h7

// Erase flags carried in the data field of a bulk program erase
`define SFP_ERA_DATA     0
`define SFP_ERA_ID       1
`define SFP_ERA_CAL1     2
`define SFP_ERA_CAL2     3

// Job lengths
`define SFP_JOB_NONE     3'h0
`define SFP_JOB_ONE      3'h1
`define SFP_JOB_FOUR     3'h4

// Link states
`define SFP_ST_CMD       2'h0
`define SFP_ST_LOAD      2'h1
`define SFP_ST_READ      2'h2

`endif

// ===== core/sfp_prog_port.v
// What this block does
// - Four-word write only inside user program memory
// - Device ID/config/calibration writes keep latches intact
// - Bulk erase in user space: program plus configuration
// - Bulk erase also clears data when data-protected
// - Bulk erase at config base adds identifiers
// - After 8/9 increments also erase calibration words
// - Six-bit commands, LSB first, sampled falling edge
// - Load/read followed by 16-clock framed data
// - Read drives from second rise, releases after sixteenth
// - Load captures LSB at second falling edge
// - Load, read and increment command codes
// - Begin, end and erase command codes
// - Data load keeps only first eight bits
// - Protected reads return zeros
// - Configuration load jumps counter to config base
// - Counter increments only, cleared on mode exit
// - Begin needs a prior load; no pre-erase
// - Row erase of PC[12:4] unless protected/config
`timescale 1ns/1ps
`include "sfp_defs.vh"

module sfp_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  // System
  input  wire             clk,
  input  wire             arst_n,
  // Fill side
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // Drain side
  output reg              out_valid,
  input  wire             out_ready,
  output reg  [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wptr;
  reg [AW-1:0]    rptr;
  reg [AW:0]      count;
  wire            push;
  wire            pop;

  assign in_ready = (count != DEPTH[AW:0]);
  assign push     = in_valid & in_ready;
  // Output register refills whenever it is empty or being taken
  assign pop      = (count != {(AW+1){1'b0}}) & (~out_valid | out_ready);

  always @(posedge clk) begin
    if (push) begin
      mem[wptr] <= in_data;
    end
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wptr      <= {AW{1'b0}};
      rptr      <= {AW{1'b0}};
      count     <= {(AW+1){1'b0}};
      out_valid <= 1'b0;
      out_data  <= {WIDTH{1'b0}};
    end else begin
      if (push) begin
        wptr <= wptr + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rptr      <= rptr + {{(AW-1){1'b0}}, 1'b1};
        out_data  <= mem[rptr];
        out_valid <= 1'b1;
      end else if (out_ready) begin
        out_valid <= 1'b0;
      end
      if (push && !pop) begin
        count <= count + {{AW{1'b0}}, 1'b1};
      end else if (pop && !push) begin
        count <= count - {{AW{1'b0}}, 1'b1};
      end
    end
  end
endmodule

module sfp_prog_port (
  // System
  input  wire        clk,
  input  wire        arst_n,
  // Programming pins
  input  wire        master_clear_hv_pin,
  input  wire        serial_prog_clock,
  input  wire        serial_prog_data_in,
  output reg         serial_prog_data_out,
  output reg         serial_prog_data_oe_n,
  // Protection bits from the configuration word, 0 = protected
  input  wire        program_code_protect_n,
  input  wire        data_code_protect_n,
  // Array read port
  output reg         mem_rd_req,
  output reg         mem_rd_space_data,
  output reg  [13:0] mem_rd_addr,
  input  wire        mem_rd_ack,
  input  wire [13:0] mem_rd_data,
  // Array operation stream
  output wire        mem_op_valid,
  input  wire        mem_op_ready,
  output wire [3:0]  mem_op,
  output wire [13:0] mem_addr,
  output wire [13:0] mem_data,
  // Status
  output reg         pv_mode
);
  reg        mc_s1, mc_s2;
  reg        ck_s1, ck_s2, ck_s3;
  reg        dt_s1, dt_s2;
  reg [1:0]  state;
  reg [3:0]  cnt;
  reg [5:0]  cmd_sh;
  reg [13:0] ld_sh;
  reg [13:0] rd_sh;
  reg        rd_prot;
  reg        rd_last;
  reg [13:0] pc;
  reg [13:0] latch [0:3];
  reg [7:0]  data_byte;
  reg        ld_data;
  reg        last_data;
  reg        loaded;
  reg [2:0]  seq_left;
  reg [1:0]  seq_k;
  reg        seq_four;
  reg        seq_clr;
  reg [3:0]  seq_op;
  reg [13:0] seq_addr;
  reg [13:0] seq_data;
  reg [31:0] fifo_out;
  integer    i;

  wire        rise     = ck_s2 & ~ck_s3;
  wire        fall     = ~ck_s2 & ck_s3;
  wire [5:0]  next_cmd = {dt_s2, cmd_sh[5:1]};
  wire [3:0]  code     = next_cmd[3:0];
  wire        sel      = next_cmd[`SFP_CMD_SEL_BIT];
  wire        in_cfg   = pc[`SFP_CFG_BIT];
  wire        idle_seq = (seq_left == `SFP_JOB_NONE);
  wire        fifo_in_ready;
  wire        push     = ~idle_seq & fifo_in_ready;
  wire [13:0] push_addr = seq_four ? {seq_addr[13:2], seq_k} : seq_addr;
  wire [13:0] push_data = seq_four ? latch[seq_k] : seq_data;
  // Device ID, configuration and calibration words (config offsets 6 to 9) leave the latches loaded
  wire        latch_keep = in_cfg && (pc[12:0] >= `SFP_DEVID_OFS) && (pc[12:0] <= `SFP_CAL2_OFS);
  wire        at_cal1  = in_cfg && (pc[12:0] == `SFP_CAL1_OFS);
  wire        at_cal2  = in_cfg && (pc[12:0] == `SFP_CAL2_OFS);

  assign mem_op   = fifo_out[31:28];
  assign mem_addr = fifo_out[27:14];
  assign mem_data = fifo_out[13:0];

  sfp_fifo #(
    .WIDTH (32),
    .DEPTH (8),
    .AW    (3)
  ) u_fifo (
    .clk       (clk),
    .arst_n    (arst_n),
    .in_valid  (~idle_seq),
    .in_ready  (fifo_in_ready),
    .in_data   ({seq_op, push_addr, push_data}),
    .out_valid (mem_op_valid),
    .out_ready (mem_op_ready),
    .out_data  (fifo_out)
  );

  // Pins cross from the programmer's domain
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mc_s1 <= 1'b0;
      mc_s2 <= 1'b0;
      ck_s1 <= 1'b0;
      ck_s2 <= 1'b0;
      ck_s3 <= 1'b0;
      dt_s1 <= 1'b0;
      dt_s2 <= 1'b0;
    end else begin
      mc_s1 <= master_clear_hv_pin;
      mc_s2 <= mc_s1;
      ck_s1 <= serial_prog_clock;
      ck_s2 <= ck_s1;
      ck_s3 <= ck_s2;
      dt_s1 <= serial_prog_data_in;
      dt_s2 <= dt_s1;
    end
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pv_mode               <= 1'b0;
      state                 <= `SFP_ST_CMD;
      cnt                   <= `SFP_CNT_ZERO;
      cmd_sh                <= 6'h00;
      ld_sh                 <= `SFP_WORD_ZERO;
      rd_sh                 <= `SFP_WORD_ZERO;
      rd_prot               <= 1'b0;
      rd_last               <= 1'b0;
      pc                    <= `SFP_ADDR_ZERO;
      data_byte             <= 8'h00;
      ld_data               <= 1'b0;
      last_data             <= 1'b0;
      loaded                <= 1'b0;
      seq_left              <= `SFP_JOB_NONE;
      seq_k                 <= 2'h0;
      seq_four              <= 1'b0;
      seq_clr               <= 1'b0;
      seq_op                <= `SFP_OP_END;
      seq_addr              <= `SFP_ADDR_ZERO;
      seq_data              <= `SFP_WORD_ZERO;
      mem_rd_req            <= 1'b0;
      mem_rd_space_data     <= 1'b0;
      mem_rd_addr           <= `SFP_ADDR_ZERO;
      serial_prog_data_out  <= 1'b0;
      serial_prog_data_oe_n <= 1'b1;
      for (i = 0; i < 4; i = i + 1) begin
        latch[i] <= `SFP_WORD_ONES;
      end
    end else begin
      pv_mode    <= mc_s2;
      mem_rd_req <= 1'b0;
      // Jobs already queued drain even across a mode exit
      if (push) begin
        seq_left <= seq_left - `SFP_JOB_ONE;
        seq_k    <= seq_k + 2'h1;
        if (seq_left == `SFP_JOB_ONE && seq_clr) begin
          for (i = 0; i < 4; i = i + 1) begin
            latch[i] <= `SFP_WORD_ONES;
          end
        end
      end
      if (!mc_s2) begin
        state                 <= `SFP_ST_CMD;
        cnt                   <= `SFP_CNT_ZERO;
        pc                    <= `SFP_ADDR_ZERO;
        loaded                <= 1'b0;
        rd_last               <= 1'b0;
        serial_prog_data_oe_n <= 1'b1;
        for (i = 0; i < 4; i = i + 1) begin
          latch[i] <= `SFP_WORD_ONES;
        end
      end else begin
        case (state)
          `SFP_ST_CMD: begin
            if (fall) begin
              cmd_sh <= next_cmd;
              cnt    <= cnt + `SFP_CNT_ONE;
              if (cnt == `SFP_CMD_LAST) begin
                cnt <= `SFP_CNT_ZERO;
                case (code)
                  `SFP_CMD_LD_CFG, `SFP_CMD_LD_PROG, `SFP_CMD_LD_DATA: begin
                    state   <= `SFP_ST_LOAD;
                    ld_data <= (code == `SFP_CMD_LD_DATA);
                    if (code == `SFP_CMD_LD_CFG) begin
                      pc <= `SFP_CFG_BASE;
                    end
                  end
                  `SFP_CMD_RD_PROG, `SFP_CMD_RD_DATA: begin
                    state             <= `SFP_ST_READ;
                    mem_rd_req        <= 1'b1;
                    mem_rd_addr       <= pc;
                    mem_rd_space_data <= code[0];
                    // Identifier words stay readable under protection
                    rd_prot <= code[0] ? ~data_code_protect_n : (~program_code_protect_n & ~in_cfg);
                  end
                  `SFP_CMD_INC: begin
                    pc <= {pc[`SFP_CFG_BIT], pc[12:0] + `SFP_ADDR_STEP};
                  end
                  `SFP_CMD_BEGIN: begin
                    if (loaded && idle_seq) begin
                      loaded   <= 1'b0;
                      seq_k    <= 2'h0;
                      seq_addr <= pc;
                      seq_four <= ~in_cfg & ~last_data;
                      seq_left <= (~in_cfg & ~last_data) ? `SFP_JOB_FOUR : `SFP_JOB_ONE;
                      seq_clr  <= ~last_data & ~latch_keep;
                      seq_data <= last_data ? {`SFP_BYTE_PAD, data_byte} : latch[pc[1:0]];
                      if (last_data) begin
                        seq_op <= sel ? `SFP_OP_DATA_EXT : `SFP_OP_DATA_INT;
                      end else begin
                        seq_op <= sel ? `SFP_OP_PROG_EXT : `SFP_OP_PROG_INT;
                      end
                    end
                  end
                  `SFP_CMD_END: begin
                    if (!sel && idle_seq) begin
                      seq_left <= `SFP_JOB_ONE;
                      seq_four <= 1'b0;
                      seq_clr  <= 1'b0;
                      seq_op   <= `SFP_OP_END;
                      seq_addr <= pc;
                      seq_data <= `SFP_WORD_ZERO;
                    end
                  end
                  `SFP_CMD_BULK_PRG: begin
                    if (idle_seq) begin
                      seq_left <= `SFP_JOB_ONE;
                      seq_four <= 1'b0;
                      seq_clr  <= 1'b0;
                      seq_op   <= `SFP_OP_BULK_PRG;
                      seq_addr <= pc;
                      seq_data <= `SFP_WORD_ZERO;
                      seq_data[`SFP_ERA_DATA] <= ~data_code_protect_n;
                      seq_data[`SFP_ERA_ID]   <= in_cfg;
                      seq_data[`SFP_ERA_CAL1] <= at_cal1 | at_cal2;
                      seq_data[`SFP_ERA_CAL2] <= at_cal2;
                    end
                  end
                  `SFP_CMD_BULK_DAT: begin
                    // Protected data memory is left alone
                    if (idle_seq && data_code_protect_n) begin
                      seq_left <= `SFP_JOB_ONE;
                      seq_four <= 1'b0;
                      seq_clr  <= 1'b0;
                      seq_op   <= `SFP_OP_BULK_DAT;
                      seq_addr <= pc;
                      seq_data <= `SFP_WORD_ZERO;
                    end
                  end
                  `SFP_CMD_ROW_ERA: begin
                    if (sel && idle_seq && program_code_protect_n && !in_cfg) begin
                      seq_left <= `SFP_JOB_ONE;
                      seq_four <= 1'b0;
                      seq_clr  <= 1'b0;
                      seq_op   <= `SFP_OP_ROW_ERA;
                      seq_addr <= {pc[13:4], `SFP_ROW_ZERO};
                      seq_data <= `SFP_WORD_ZERO;
                    end
                  end
                  default: begin
                    cnt <= `SFP_CNT_ZERO;
                  end
                endcase
              end
            end
          end
          `SFP_ST_LOAD: begin
            if (fall) begin
              cnt <= cnt + `SFP_CNT_ONE;
              if (cnt >= `SFP_DATA_FIRST && cnt <= `SFP_DATA_LAST) begin
                ld_sh <= {dt_s2, ld_sh[13:1]};
              end
              if (cnt == `SFP_FRAME_LAST) begin
                state     <= `SFP_ST_CMD;
                cnt       <= `SFP_CNT_ZERO;
                loaded    <= 1'b1;
                last_data <= ld_data;
                if (ld_data) begin
                  data_byte <= ld_sh[7:0];
                end else begin
                  latch[pc[1:0]] <= ld_sh;
                end
              end
            end
          end
          `SFP_ST_READ: begin
            if (mem_rd_ack) begin
              if (rd_prot) begin
                rd_sh <= `SFP_WORD_ZERO;
              end else if (mem_rd_space_data) begin
                rd_sh <= {`SFP_BYTE_PAD, mem_rd_data[7:0]};
              end else begin
                rd_sh <= mem_rd_data;
              end
            end
            if (rise) begin
              cnt <= cnt + `SFP_CNT_ONE;
              if (cnt >= `SFP_DATA_FIRST && cnt <= `SFP_DATA_LAST) begin
                serial_prog_data_oe_n <= 1'b0;
                serial_prog_data_out  <= rd_sh[0];
                rd_sh                 <= {1'b0, rd_sh[13:1]};
              end
              if (cnt == `SFP_FRAME_LAST) begin
                serial_prog_data_out <= 1'b0;
                rd_last              <= 1'b1;
              end
            end
            if (fall && rd_last) begin
              serial_prog_data_oe_n <= 1'b1;
              rd_last               <= 1'b0;
              state                 <= `SFP_ST_CMD;
              cnt                   <= `SFP_CNT_ZERO;
            end
          end
          default: begin
            state <= `SFP_ST_CMD;
          end
        endcase
      end
    end
  end
endmodule

// ===== sim/sfp_prog_port_bench.sv
`timescale 1ns/1ps
module sfp_prog_port_bench;
  reg         clk, arst_n, hv, cp_n, cpd_n, rdy, rd_ack, flt;
  reg  [13:0] rd_data, w;
  wire        sclk, p_val, p_en, d_out, d_oe_n, rd_req, rd_sp, op_valid, pv;
  wire [13:0] rd_addr, m_addr, m_data;
  wire [3:0]  m_op;
  wire        line = !d_oe_n ? d_out : (p_en ? p_val : flt);
  integer     err_count, n_tests;
  reg  [31:0] ops[$];

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  sfp_prog_port u_dut (.clk(clk), .arst_n(arst_n), .master_clear_hv_pin(hv), .serial_prog_clock(sclk),
    .serial_prog_data_in(line), .serial_prog_data_out(d_out), .serial_prog_data_oe_n(d_oe_n),
    .program_code_protect_n(cp_n), .data_code_protect_n(cpd_n), .mem_rd_req(rd_req),
    .mem_rd_space_data(rd_sp), .mem_rd_addr(rd_addr), .mem_rd_ack(rd_ack), .mem_rd_data(rd_data),
    .mem_op_valid(op_valid), .mem_op_ready(rdy), .mem_op(m_op), .mem_addr(m_addr), .mem_data(m_data),
    .pv_mode(pv));
  sfp_programmer u_prg (.clk(clk), .sclk(sclk), .dat_val(p_val), .dat_en(p_en), .dat_line(line));

  // Array stand-in; an undriven pin toggles so a stale bit never reads as valid
  always @(posedge clk) begin
    flt <= ~line;
    rd_ack <= rd_req;
    rd_data <= rd_addr ^ 14'h2a5c;
    if (op_valid && rdy)
      ops.push_back({m_op, m_addr, m_data});
  end

  task chk(input [31:0] got, input [31:0] exp, input string what);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("[FAIL] %0t %s: got %h want %h", $time, what, got, exp);
      end
    end
  endtask
  task end_sim;
    begin
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  task chk_op(input [3:0] op, input [13:0] a, input [13:0] d, input [31:0] m, input string what);
    integer i;
    begin
      for (i = 0; i < 300 && ops.size() == 0; i = i + 1) @(negedge clk);
      if (ops.size() == 0) begin
        err_count = err_count + 1;
        $display("[FAIL] %0t no op for %s", $time, what);
        end_sim;
      end
      chk(ops.pop_front() & m, {op, a, d} & m, what);
    end
  endtask
  task none(input string what);
    begin
      repeat (60) @(negedge clk);
      chk(ops.size(), 0, what);
    end
  endtask
  task send(input [5:0] c);
    u_prg.cmd(c, 110);
  endtask
  task bulk(input [3:0] f);
    begin
      send(6'h39);
      chk_op(4'h5, 14'h0000, {10'h000, f}, 32'hf000_000f, "bulk erase");
    end
  endtask

  task s_quad;
    integer i;
    begin
      rdy = 1'b0;
      for (i = 0; i < 4; i = i + 1) begin
        if (i > 0) send(6'h36);
        send(6'h32);
        u_prg.load(14'h0111 * (i + 1));
      end
      send(6'h28);
      repeat (40) @(negedge clk);
      rdy = 1'b1;
      for (i = 0; i < 4; i = i + 1)
        chk_op(4'h0, i, 14'h0111 * (i + 1), 32'hffff_ffff, "quad write");
      send(6'h06);
    end
  endtask
  task s_ext;
    integer i;
    begin
      send(6'h02);
      u_prg.load(14'h0abc);
      send(6'h18);
      for (i = 0; i < 4; i = i + 1)
        chk_op(4'h1, 4 + i, i == 0 ? 14'h0abc : 14'h3fff, 32'hffff_ffff, "timed write");
      u_prg.cmd(6'h2a, 10010);
      chk_op(4'h4, 14'h0000, 14'h0000, 32'hf000_0000, "end programming");
      send(6'h08);
      none("begin without load");
      send(6'h06);
    end
  endtask
  task s_read;
    integer i;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        cp_n = i != 1;
        cpd_n = i != 3;
        send(i < 2 ? 6'h04 : 6'h05);
        u_prg.read(w);
        chk(w, i == 0 ? 14'h2a59 : i == 2 ? 14'h0059 : 14'h0000, "read word");
        chk(d_oe_n, 1'b1, "pin released");
        chk(rd_sp, i > 1, "read space");
      end
      chk(rd_addr, 14'h0005, "read address");
      cpd_n = 1'b1;
      send(6'h03);
      u_prg.load(14'h3fab);
      send(6'h08);
      chk_op(4'h2, 14'h0005, 14'h00ab, 32'hffff_ffff, "data write");
      none("extra data op");
    end
  endtask
  task s_erase;
    integer i;
    begin
      for (i = 0; i < 12; i = i + 1) send(6'h06);
      send(6'h31);
      chk_op(4'h7, 14'h0010, 14'h0000, 32'hffff_c000, "row erase");
      cp_n = 1'b0;
      send(6'h11);
      none("protected row erase");
      cp_n = 1'b1;
      send(6'h0b);
      chk_op(4'h6, 14'h0000, 14'h0000, 32'hf000_0000, "data erase");
      cpd_n = 1'b0;
      send(6'h3b);
      none("protected data erase");
      bulk(4'h1);
      cpd_n = 1'b1;
      bulk(4'h0);
    end
  endtask
  task s_cfg;
    integer i;
    begin
      send(6'h00);
      u_prg.load(14'h3fff);
      send(6'h31);
      none("row erase in config");
      bulk(4'h2);
      for (i = 0; i < 8; i = i + 1) send(6'h06);
      bulk(4'h6);
      send(6'h06);
      bulk(4'he);
      cp_n = 1'b0;
      send(6'h04);
      u_prg.read(w);
      chk(w, 14'h0a55, "config read");
      chk(rd_addr, 14'h2009, "config address");
      cp_n = 1'b1;
      send(6'h02);
      u_prg.load(14'h1234);
      send(6'h28);
      chk_op(4'h0, 14'h2009, 14'h1234, 32'hffff_ffff, "config write");
      none("extra config op");
      // Latches survive a calibration write, so fill them by hand
      for (i = 0; i < 4; i = i + 1) begin
        send(6'h02);
        u_prg.load(14'h3fff);
        send(6'h06);
      end
      none("latch clear loads");
    end
  endtask
  task s_exit;
    begin
      hv = 1'b0;
      repeat (10) @(negedge clk);
      chk(pv, 1'b0, "mode exit");
      hv = 1'b1;
      repeat (10) @(negedge clk);
      chk(pv, 1'b1, "mode entry");
      send(6'h04);
      u_prg.read(w);
      chk(rd_addr, 14'h0000, "counter cleared");
      chk(w, 14'h2a5c, "read after entry");
    end
  endtask

  initial begin
    err_count = 0;
    n_tests = 0;
    arst_n = 1'b0;
    hv = 1'b1;
    cp_n = 1'b1;
    cpd_n = 1'b1;
    rdy = 1'b1;
    rd_ack = 1'b0;
    rd_data = 14'h0000;
    flt = 1'b0;
    repeat (2) @(negedge clk);
    arst_n = 1'b1;
    repeat (6) @(negedge clk);
    chk(d_oe_n, 1'b1, "idle pin");
    chk(op_valid, 1'b0, "idle stream");
    s_quad;
    s_ext;
    s_read;
    s_erase;
    s_cfg;
    s_exit;
    end_sim;
  end
endmodule

// ===== sim/sfp_prog_port_props.sv
`timescale 1ns/1ps
module sfp_prog_port_props (
  // System
  input wire        clk,
  input wire        arst_n,
  // Pins
  input wire        master_clear_hv_pin,
  input wire        serial_prog_clock,
  input wire        serial_prog_data_oe_n,
  input wire        pv_mode,
  // Array side
  input wire        mem_rd_req,
  input wire        mem_op_valid,
  input wire        mem_op_ready,
  input wire [3:0]  mem_op,
  input wire [13:0] mem_addr,
  input wire [13:0] mem_data
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  a_rd_pulse: assert property (mem_rd_req |=> !mem_rd_req)
    else $error("read request wider than one cycle");
  a_op_hold: assert property (mem_op_valid && !mem_op_ready |=>
    mem_op_valid && $stable({mem_op, mem_addr, mem_data})) else $error("stalled op changed");
  a_pv_entry: assert property ($rose(master_clear_hv_pin) |-> ##[1:4] pv_mode)
    else $error("mode entry not seen");
  a_exit_release: assert property (!master_clear_hv_pin [*5] |-> serial_prog_data_oe_n)
    else $error("data pin driven outside mode");
  a_drive_start: assert property ($fell(serial_prog_data_oe_n) |-> serial_prog_clock && pv_mode)
    else $error("drive began outside a high clock phase");
  a_drive_end: assert property ($rose(serial_prog_data_oe_n) |-> !serial_prog_clock || !pv_mode)
    else $error("release not after a falling clock");
  a_row_align: assert property (mem_op_valid && mem_op == 4'h7 |->
    mem_addr[3:0] == 4'h0 && !mem_addr[13]) else $error("row erase address wrong");
  a_byte_pad: assert property (mem_op_valid && mem_op[3:1] == 3'h1 |-> mem_data[13:8] == 6'h00)
    else $error("data byte not padded with zeros");
  a_cal_order: assert property (mem_op_valid && mem_op == 4'h5 |->
    (!mem_data[2] || mem_data[1]) && (!mem_data[3] || mem_data[2])) else $error("erase flags inconsistent");
endmodule

bind sfp_prog_port sfp_prog_port_props u_props (.clk(clk), .arst_n(arst_n),
  .master_clear_hv_pin(master_clear_hv_pin), .serial_prog_clock(serial_prog_clock),
  .serial_prog_data_oe_n(serial_prog_data_oe_n), .pv_mode(pv_mode), .mem_rd_req(mem_rd_req),
  .mem_op_valid(mem_op_valid), .mem_op_ready(mem_op_ready), .mem_op(mem_op),
  .mem_addr(mem_addr), .mem_data(mem_data));

// ===== sim/sfp_programmer.sv
`timescale 1ns/1ps
module sfp_programmer (
  // System
  input  wire clk,
  // Link
  output reg  sclk,
  output reg  dat_val,
  output reg  dat_en,
  input  wire dat_line
);
  reg [16:0] smp;
  initial begin
    sclk = 1'b0;
    dat_val = 1'b0;
    dat_en = 1'b1;
    smp = 17'h0_0000;
  end
  // One 80 ns serial cycle; the line is sampled just before each rise
  task cyc(input b, input drv);
    begin
      @(negedge clk);
      smp = {dat_line, smp[16:1]};
      sclk = 1'b1;
      dat_en = drv;
      dat_val = b;
      repeat (4) @(negedge clk);
      sclk = 1'b0;
      repeat (3) @(negedge clk);
    end
  endtask
  task cmd(input [5:0] c, input integer g);
    integer i;
    begin
      for (i = 0; i < 6; i = i + 1) cyc(c[i], 1'b1);
      repeat (g) @(negedge clk);
    end
  endtask
  task load(input [13:0] w);
    integer i;
    begin
      cyc(1'b0, 1'b1);
      for (i = 0; i < 14; i = i + 1) cyc(w[i], 1'b1);
      cyc(1'b0, 1'b1);
      repeat (110) @(negedge clk);
    end
  endtask
  // Released for the whole frame so the device can turn the pin round
  task read(output [13:0] w);
    integer i;
    begin
      for (i = 0; i < 16; i = i + 1) cyc(1'b0, 1'b0);
      @(negedge clk);
      smp = {dat_line, smp[16:1]};
      w = smp[15:2];
      repeat (110) @(negedge clk);
    end
  endtask
endmodule
